// ===== design/pio_pkg.sv
// Constants for the four parallel I/O ports: map, widths, reset values.
//----------------------------------------------------------------------
// Overview of operation
// - Written output data is held in latches; pin inputs are never latched.
// - A pin-read access edge returns pin levels sampled two edges earlier by the synchroniser.
// - Driven pin level changes on the clock edge after the write access edge.
// - First port segment-select bit 1 routes pin to LCD segment output.
// - Reset sets all latch bits of first, second and fifth ports to 1.
// - Latch and live pin levels are readable at separate addresses.
// - Pin-read of a segment-configured bit returns an unreliable value.
// - Dual-clock mode gives upper second-port pins to the slow oscillator.
// - Falling edge on second port bit 0 raises the external interrupt.
// - Unimplemented upper bits of second and third port reads return zero.
// - In stop mode second port bit 0 floats whatever output enable says.
// - Third port drive-type 0 gives sink open-drain, 1 gives push-pull.
// - Reset sets third port latch to ones and drive-type to zeros.
// - Fifth port segment-select 1 routes pin to LCD segment output.
//----------------------------------------------------------------------
`default_nettype none

package pio_pkg;

    //------------------------------------------------------------------
    // Register offsets on the CPU special function space
    //------------------------------------------------------------------
    localparam int OFF_W = 6;
    localparam logic [OFF_W-1:0] OFF_P1_LATCH = 6'h01;
    localparam logic [OFF_W-1:0] OFF_P2_LATCH = 6'h02;
    localparam logic [OFF_W-1:0] OFF_P3_LATCH = 6'h03;
    localparam logic [OFF_W-1:0] OFF_P3_DRIVE = 6'h04;
    localparam logic [OFF_W-1:0] OFF_P5_LATCH = 6'h05;
    localparam logic [OFF_W-1:0] OFF_P1_PIN = 6'h08;
    localparam logic [OFF_W-1:0] OFF_P2_PIN = 6'h09;
    localparam logic [OFF_W-1:0] OFF_P3_PIN = 6'h0a;
    localparam logic [OFF_W-1:0] OFF_P5_PIN = 6'h0b;
    localparam logic [OFF_W-1:0] OFF_P1_SEG = 6'h29;
    localparam logic [OFF_W-1:0] OFF_P5_SEG = 6'h2a;

    //------------------------------------------------------------------
    // Port widths and positions in the combined pin vector
    //------------------------------------------------------------------
    localparam int P1_W = 8;
    localparam int P2_W = 3;
    localparam int P3_W = 4;
    localparam int P5_W = 8;
    localparam int P1_LSB = 0;
    localparam int P2_LSB = P1_LSB + P1_W;
    localparam int P3_LSB = P2_LSB + P2_W;
    localparam int P5_LSB = P3_LSB + P3_W;
    localparam int PINS_W = P5_LSB + P5_W;

    // Second port bit roles
    localparam int STOP_PIN_BIT = 0;
    localparam int OSC_A_BIT = 1;
    localparam int OSC_B_BIT = 2;

    //------------------------------------------------------------------
    // Reset values
    //------------------------------------------------------------------
    localparam logic [P1_W-1:0] P1_LATCH_RST = 8'hff;
    localparam logic [P2_W-1:0] P2_LATCH_RST = 3'h7;
    localparam logic [P3_W-1:0] P3_LATCH_RST = 4'hf;
    localparam logic [P3_W-1:0] P3_DRIVE_RST = 4'h0;
    localparam logic [P5_W-1:0] P5_LATCH_RST = 8'hff;
    localparam logic [P1_W-1:0] P1_SEG_RST = 8'h00;
    localparam logic [P5_W-1:0] P5_SEG_RST = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

endpackage

`default_nettype wire

// ===== design/pio_sync_if.sv
// Interface carrying raw pins, synchronised levels and falling edges.
`default_nettype none

interface pio_sync_if #(parameter int W = 23);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    logic [W-1:0] fall;

    modport sync_side (input raw, output sync, output fall);
    modport user_side (output raw, input sync, input fall);
endinterface

`default_nettype wire

// ===== design/pio_sync.sv
// Two-flop pin synchroniser with falling-edge detection per bit.
`default_nettype none

module pio_sync
    import pio_pkg::*;
#(
    parameter int W = PINS_W
)(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    pio_sync_if.sync_side sif
);

    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;

    //------------------------------------------------------------------
    // Synchroniser chain; the first stage feeds only the second
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta <= '1;
            stable <= '1;
            prev <= '1;
        end else begin
            meta <= sif.raw;
            stable <= meta;
            prev <= stable;
        end
    end

    // Edge taken between the settled stages only
    assign sif.sync = stable;
    assign sif.fall = prev & ~stable;

endmodule

`default_nettype wire

// ===== design/pio_ports.sv
// Four parallel I/O ports with latches, pin reads and segment routing.
`default_nettype none

module pio_ports
    import pio_pkg::*;
#(
    parameter int ADDR_W = 6
)(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire logic cpu_rd_i,
    input wire logic cpu_wr_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic [7:0] cpu_rdata_o,
    input wire logic dual_clock_mode_i,
    input wire logic stop_mode_i,
    input wire logic global_output_enable_i,
    input wire logic [P1_W-1:0] seg1_data_i,
    input wire logic [P5_W-1:0] seg5_data_i,
    input wire logic [P1_W-1:0] p1_pin_i,
    output logic [P1_W-1:0] p1_pin_o,
    output logic [P1_W-1:0] p1_pin_oe_o,
    input wire logic [P2_W-1:0] p2_pin_i,
    output logic [P2_W-1:0] p2_pin_o,
    output logic [P2_W-1:0] p2_pin_oe_o,
    input wire logic [P3_W-1:0] p3_pin_i,
    output logic [P3_W-1:0] p3_pin_o,
    output logic [P3_W-1:0] p3_pin_oe_o,
    input wire logic [P5_W-1:0] p5_pin_i,
    output logic [P5_W-1:0] p5_pin_o,
    output logic [P5_W-1:0] p5_pin_oe_o,
    output logic ext_int_fall_o
);

    //------------------------------------------------------------------
    // Elaboration check
    //------------------------------------------------------------------
    if (ADDR_W < OFF_W) begin : g_addr_check
        $error("pio_ports: ADDR_W too narrow for the register map");
    end

    //------------------------------------------------------------------
    // Storage
    //------------------------------------------------------------------
    logic [P1_W-1:0] port1_out_latch;
    logic [P2_W-1:0] port2_out_latch;
    logic [P3_W-1:0] port3_out_latch;
    logic [P5_W-1:0] port5_out_latch;
    logic [P3_W-1:0] port3_drive_type;
    logic [P1_W-1:0] port1_segment_select;
    logic [P5_W-1:0] port5_segment_select;

    logic [P1_W-1:0] port1_pin_read;
    logic [P2_W-1:0] port2_pin_read;
    logic [P3_W-1:0] port3_pin_read;
    logic [P5_W-1:0] port5_pin_read;

    //------------------------------------------------------------------
    // Pin synchronisation
    //------------------------------------------------------------------
    pio_sync_if #(.W(PINS_W)) sif ();

    // Pins are async to the core clock, so they pass two flops first
    assign sif.raw = {p5_pin_i, p3_pin_i, p2_pin_i, p1_pin_i};

    pio_sync #(
        .W(PINS_W)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .sif(sif)
    );

    // Live pin levels, never stored in a latch
    assign port1_pin_read = sif.sync[P1_LSB +: P1_W];
    assign port2_pin_read = sif.sync[P2_LSB +: P2_W];
    assign port3_pin_read = sif.sync[P3_LSB +: P3_W];
    assign port5_pin_read = sif.sync[P5_LSB +: P5_W];

    //------------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------------
    logic hit_p1_latch;
    logic hit_p2_latch;
    logic hit_p3_latch;
    logic hit_p3_drive;
    logic hit_p5_latch;
    logic hit_p1_seg;
    logic hit_p5_seg;

    // One register per address, so a write reaches only its own port
    assign hit_p1_latch = cpu_addr_i == ADDR_W'(OFF_P1_LATCH);
    assign hit_p2_latch = cpu_addr_i == ADDR_W'(OFF_P2_LATCH);
    assign hit_p3_latch = cpu_addr_i == ADDR_W'(OFF_P3_LATCH);
    assign hit_p3_drive = cpu_addr_i == ADDR_W'(OFF_P3_DRIVE);
    assign hit_p5_latch = cpu_addr_i == ADDR_W'(OFF_P5_LATCH);
    assign hit_p1_seg = cpu_addr_i == ADDR_W'(OFF_P1_SEG);
    assign hit_p5_seg = cpu_addr_i == ADDR_W'(OFF_P5_SEG);

    //------------------------------------------------------------------
    // Output latches
    //------------------------------------------------------------------
    // Latches reset high so every pin starts released as an input
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port1_out_latch <= P1_LATCH_RST;
            port2_out_latch <= P2_LATCH_RST;
            port3_out_latch <= P3_LATCH_RST;
            port5_out_latch <= P5_LATCH_RST;
        end else if (cpu_wr_i) begin
            if (hit_p1_latch) begin
                port1_out_latch <= cpu_wdata_i;
            end
            if (hit_p2_latch) begin
                port2_out_latch <= cpu_wdata_i[P2_W-1:0];
            end
            if (hit_p3_latch) begin
                port3_out_latch <= cpu_wdata_i[P3_W-1:0];
            end
            if (hit_p5_latch) begin
                port5_out_latch <= cpu_wdata_i;
            end
        end
    end

    //------------------------------------------------------------------
    // Configuration registers
    //------------------------------------------------------------------
    // Drive type resets to open-drain so nothing fights the board
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port3_drive_type <= P3_DRIVE_RST;
            port1_segment_select <= P1_SEG_RST;
            port5_segment_select <= P5_SEG_RST;
        end else if (cpu_wr_i) begin
            if (hit_p3_drive) begin
                port3_drive_type <= cpu_wdata_i[P3_W-1:0];
            end
            if (hit_p1_seg) begin
                port1_segment_select <= cpu_wdata_i;
            end
            if (hit_p5_seg) begin
                port5_segment_select <= cpu_wdata_i;
            end
        end
    end

    //------------------------------------------------------------------
    // Read data path
    //------------------------------------------------------------------
    logic [7:0] next_rdata;

    // Pure mux: reads never disturb any register
    always_comb begin
        next_rdata = RDATA_IDLE;
        unique case (1'b1)
            cpu_addr_i == ADDR_W'(OFF_P1_LATCH): begin
                next_rdata = port1_out_latch;
            end
            cpu_addr_i == ADDR_W'(OFF_P2_LATCH): begin
                next_rdata = {5'h00, port2_out_latch};
            end
            cpu_addr_i == ADDR_W'(OFF_P3_LATCH): begin
                next_rdata = {4'h0, port3_out_latch};
            end
            cpu_addr_i == ADDR_W'(OFF_P3_DRIVE): begin
                next_rdata = {4'h0, port3_drive_type};
            end
            cpu_addr_i == ADDR_W'(OFF_P5_LATCH): begin
                next_rdata = port5_out_latch;
            end
            cpu_addr_i == ADDR_W'(OFF_P1_PIN): begin
                // Segment bits read back whatever the pad shows
                next_rdata = port1_pin_read;
            end
            cpu_addr_i == ADDR_W'(OFF_P2_PIN): begin
                next_rdata = {5'h00, port2_pin_read};
            end
            cpu_addr_i == ADDR_W'(OFF_P3_PIN): begin
                next_rdata = {4'h0, port3_pin_read};
            end
            cpu_addr_i == ADDR_W'(OFF_P5_PIN): begin
                next_rdata = port5_pin_read;
            end
            cpu_addr_i == ADDR_W'(OFF_P1_SEG): begin
                next_rdata = port1_segment_select;
            end
            cpu_addr_i == ADDR_W'(OFF_P5_SEG): begin
                next_rdata = port5_segment_select;
            end
            default: begin
                next_rdata = RDATA_IDLE;
            end
        endcase
    end

    // The read edge captures pin levels the synchroniser sampled two edges earlier
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cpu_rdata_o <= RDATA_IDLE;
        end else if (cpu_rd_i) begin
            cpu_rdata_o <= next_rdata;
        end else begin
            cpu_rdata_o <= RDATA_IDLE;
        end
    end

    //------------------------------------------------------------------
    // Pin drive
    //------------------------------------------------------------------
    logic outputs_off;
    logic [P1_W-1:0] next_p1_o;
    logic [P1_W-1:0] next_p1_oe;
    logic [P2_W-1:0] next_p2_oe;
    logic [P3_W-1:0] next_p3_o;
    logic [P3_W-1:0] next_p3_oe;
    logic [P5_W-1:0] next_p5_o;
    logic [P5_W-1:0] next_p5_oe;

    // Stop mode floats every pad unless software keeps outputs on
    assign outputs_off = stop_mode_i & ~global_output_enable_i;

    // Plain bits sink when latch is 0 and release when it is 1
    always_comb begin
        next_p1_o = port1_segment_select & seg1_data_i;
        next_p1_oe = port1_segment_select | ~port1_out_latch;
        next_p5_o = port5_segment_select & seg5_data_i;
        next_p5_oe = port5_segment_select | ~port5_out_latch;
        next_p2_oe = ~port2_out_latch;
        next_p3_o = port3_drive_type & port3_out_latch;
        next_p3_oe = port3_drive_type | ~port3_out_latch;
        if (outputs_off) begin
            next_p1_oe = '0;
            next_p5_oe = '0;
            next_p2_oe = '0;
            next_p3_oe = '0;
        end
        if (dual_clock_mode_i) begin
            // Crystal owns these pads; driving them would stop it
            next_p2_oe[OSC_A_BIT] = 1'b0;
            next_p2_oe[OSC_B_BIT] = 1'b0;
        end
        if (stop_mode_i) begin
            // Stop-release input must float regardless of enable
            next_p2_oe[STOP_PIN_BIT] = 1'b0;
        end
    end

    // Pads update on the edge after the write edge
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            p1_pin_o <= '0;
            p1_pin_oe_o <= '0;
            p2_pin_o <= '0;
            p2_pin_oe_o <= '0;
            p3_pin_o <= '0;
            p3_pin_oe_o <= '0;
            p5_pin_o <= '0;
            p5_pin_oe_o <= '0;
        end else begin
            p1_pin_o <= next_p1_o;
            p1_pin_oe_o <= next_p1_oe;
            p2_pin_o <= '0;
            p2_pin_oe_o <= next_p2_oe;
            p3_pin_o <= next_p3_o;
            p3_pin_oe_o <= next_p3_oe;
            p5_pin_o <= next_p5_o;
            p5_pin_oe_o <= next_p5_oe;
        end
    end

    //------------------------------------------------------------------
    // External interrupt edge
    //------------------------------------------------------------------
    // Seen even when the pin is our own output, so keep it an input
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_int_fall_o <= 1'b0;
        end else begin
            ext_int_fall_o <= sif.fall[P2_LSB + STOP_PIN_BIT];
        end
    end

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_wr_p1;
        cpu_wr_i && hit_p1_latch;
    endsequence

    sequence s_rd_pin1;
        cpu_rd_i && cpu_addr_i == ADDR_W'(OFF_P1_PIN);
    endsequence

    sequence s_plain_p1;
        port1_segment_select == 8'h00 && !stop_mode_i;
    endsequence

    latch_write_a: assert property (
        s_wr_p1 |=> port1_out_latch == $past(cpu_wdata_i)
    ) else $error("port1 latch missed a write");

    write_isolate_a: assert property (
        s_wr_p1 |=> $stable(port2_out_latch) && $stable(port5_out_latch)
            && $stable(port3_out_latch)
    ) else $error("write to port1 disturbed another port");

    pad_follow_a: assert property (
        (s_wr_p1 ##1 s_plain_p1) |=> p1_pin_oe_o == ~$past(cpu_wdata_i, 2)
    ) else $error("port1 pad did not follow the written latch");

    pin_read_a: assert property (
        s_rd_pin1 |=> cpu_rdata_o == $past(port1_pin_read)
    ) else $error("pin read did not return sampled pins");

    latch_read_a: assert property (
        cpu_rd_i && cpu_addr_i == ADDR_W'(OFF_P5_LATCH)
            |=> cpu_rdata_o == $past(port5_out_latch)
    ) else $error("latch read did not return latch");

    read_quiet_a: assert property (
        cpu_rd_i && !cpu_wr_i |=> $stable(port1_out_latch)
            && $stable(port3_drive_type)
    ) else $error("read changed a register");

    // Checked per bit, so a partial segment select is covered as well
    seg_route_a: assert property (
        !outputs_off |=> (p1_pin_oe_o & $past(port1_segment_select))
            == $past(port1_segment_select)
            && (p1_pin_o & $past(port1_segment_select))
            == $past(port1_segment_select & seg1_data_i)
    ) else $error("segment bits not routed to pads");

    stop_float_a: assert property (
        stop_mode_i |=> !p2_pin_oe_o[STOP_PIN_BIT]
    ) else $error("stop-release pin driven in stop mode");

    osc_share_a: assert property (
        dual_clock_mode_i |=> p2_pin_oe_o[OSC_B_BIT:OSC_A_BIT] == 2'h0
    ) else $error("oscillator pins driven in dual-clock mode");

    push_pull_a: assert property (
        !outputs_off |=> (p3_pin_oe_o & $past(port3_drive_type))
            == $past(port3_drive_type)
            && (p3_pin_o & $past(port3_drive_type))
            == $past(port3_drive_type & port3_out_latch)
            && (p3_pin_o & ~$past(port3_drive_type)) == 4'h0
    ) else $error("third port push-pull drive wrong");

    fall_int_a: assert property (
        $fell(port2_pin_read[STOP_PIN_BIT]) |=> ext_int_fall_o ##1
            !ext_int_fall_o
    ) else $error("falling edge did not pulse the interrupt once");

    narrow_read_a: assert property (
        cpu_rd_i && cpu_addr_i == ADDR_W'(OFF_P2_PIN)
            |=> cpu_rdata_o[7:3] == 5'h00
    ) else $error("unused port2 read bits not zero");

endmodule

`default_nettype wire

// ===== tb/pio_pad_model.sv
// Board-side model of the port pads: pull-ups and external drivers.
`default_nettype none

module pio_pad_model #(
    parameter int W = 23
)(
    input wire logic [W-1:0] pad_o_i,
    input wire logic [W-1:0] pad_oe_i,
    input wire logic [W-1:0] ext_en_i,
    input wire logic [W-1:0] ext_val_i,
    output logic [W-1:0] pad_i_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Device drive wins; a released pad with no board driver is pulled
    // up, so an open-drain bit with latch 1 reads back as an input
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pad_oe_i[i])
                pad_i_o[i] = pad_o_i[i];
            else if (ext_en_i[i])
                pad_i_o[i] = ext_val_i[i];
            else
                pad_i_o[i] = 1'b1;
        end
    end
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the parallel I/O ports.
`default_nettype none

module tb_top
    import pio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [5:0] addr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic dual = 1'b0;
    logic stop = 1'b0;
    logic goe = 1'b1;
    logic [7:0] seg1 = 8'h00;
    logic [7:0] seg5 = 8'h00;
    logic [PINS_W-1:0] ext_en = '0;
    logic [PINS_W-1:0] ext_val = '0;
    wire [7:0] rdata;
    wire [PINS_W-1:0] pad_o;
    wire [PINS_W-1:0] pad_oe;
    wire [PINS_W-1:0] pad_i;
    wire int_fall;
    int mismatches = 0;
    int num_checks = 0;
    int n_int = 0;
    int n0;

    always #10 ref_clk_i = ~ref_clk_i;

    // Count interrupt pulses; each lasts exactly one cycle
    always @(posedge ref_clk_i) begin
        if (int_fall === 1'b1)
            n_int++;
    end

    pio_ports DUT (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .cpu_addr_i(addr), .cpu_rd_i(rd), .cpu_wr_i(wr),
        .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
        .dual_clock_mode_i(dual), .stop_mode_i(stop),
        .global_output_enable_i(goe),
        .seg1_data_i(seg1), .seg5_data_i(seg5),
        .p1_pin_i(pad_i[P1_LSB+:P1_W]), .p1_pin_o(pad_o[P1_LSB+:P1_W]),
        .p1_pin_oe_o(pad_oe[P1_LSB+:P1_W]),
        .p2_pin_i(pad_i[P2_LSB+:P2_W]), .p2_pin_o(pad_o[P2_LSB+:P2_W]),
        .p2_pin_oe_o(pad_oe[P2_LSB+:P2_W]),
        .p3_pin_i(pad_i[P3_LSB+:P3_W]), .p3_pin_o(pad_o[P3_LSB+:P3_W]),
        .p3_pin_oe_o(pad_oe[P3_LSB+:P3_W]),
        .p5_pin_i(pad_i[P5_LSB+:P5_W]), .p5_pin_o(pad_o[P5_LSB+:P5_W]),
        .p5_pin_oe_o(pad_oe[P5_LSB+:P5_W]),
        .ext_int_fall_o(int_fall)
    );

    pio_pad_model #(.W(PINS_W)) pads (
        .pad_o_i(pad_o), .pad_oe_i(pad_oe), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pad_i_o(pad_i)
    );

    //------------------------------------------------------------------
    // Access tasks: one-cycle strobes, read data one cycle later
    //------------------------------------------------------------------
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string m);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, m, got, exp);
        end
    endtask

    task automatic rchk(input logic [5:0] a, input logic [7:0] exp,
                        input string m);
        @(posedge ref_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, m);
    endtask

    // Long enough for pads to pass the two-flop synchroniser
    task automatic settle;
        repeat (8) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    //------------------------------------------------------------------
    // Test sequence
    //------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        rchk(OFF_P1_LATCH, 8'hff, "p1 latch");
        rchk(OFF_P2_LATCH, 8'h07, "p2 latch");
        rchk(OFF_P5_LATCH, 8'hff, "p5 latch");
        rchk(OFF_P3_LATCH, 8'h0f, "p3 latch");
        rchk(OFF_P3_DRIVE, 8'h00, "p3 drive");
        chk({4'h0, pad_oe[P3_LSB+:P3_W]}, 8'h00, "p3 oe");
        $display("test reset values done");
        wr_reg(OFF_P1_LATCH, 8'h5a);
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk(pad_oe[P1_LSB+:P1_W], 8'ha5, "p1 oe");
        rchk(OFF_P5_LATCH, 8'hff, "p5 kept");
        // Board pulls the released low bits down and holds them
        ext_en[P1_LSB+:P1_W] <= 8'h0f;
        settle;
        rchk(OFF_P1_PIN, 8'h50, "p1 pins");
        rchk(OFF_P1_LATCH, 8'h5a, "p1 latch kept");
        wr_reg(OFF_P1_PIN, 8'h00);
        rchk(OFF_P1_LATCH, 8'h5a, "pin write ignored");
        rchk(6'h3f, 8'h00, "unmapped read");
        $display("test latch and pins done");
        seg1 <= 8'ha5;
        seg5 <= 8'h80;
        ext_en[P5_LSB+:P5_W] <= 8'h0f;
        wr_reg(OFF_P1_SEG, 8'h0f);
        wr_reg(OFF_P5_SEG, 8'h80);
        settle;
        chk(pad_oe[P1_LSB+:P1_W], 8'haf, "p1 seg oe");
        chk(pad_o[P1_LSB+:P1_W], 8'h05, "p1 seg out");
        chk(pad_oe[P5_LSB+:P5_W], 8'h80, "p5 seg oe");
        chk(pad_o[P5_LSB+:P5_W], 8'h80, "p5 seg out");
        rchk(OFF_P1_SEG, 8'h0f, "p1 seg reg");
        rchk(OFF_P5_SEG, 8'h80, "p5 seg reg");
        rchk(OFF_P5_PIN, 8'hf0, "p5 pins");
        $display("test segments done");
        wr_reg(OFF_P3_LATCH, 8'h05);
        wr_reg(OFF_P3_DRIVE, 8'h03);
        settle;
        chk({4'h0, pad_oe[P3_LSB+:P3_W]}, 8'h0b, "p3 oe");
        chk({4'h0, pad_o[P3_LSB+:P3_W]}, 8'h01, "p3 out");
        rchk(OFF_P3_PIN, 8'h05, "p3 pins");
        $display("test drive type done");
        n0 = n_int;
        wr_reg(OFF_P2_LATCH, 8'h00);
        settle;
        chk({5'h00, pad_oe[P2_LSB+:P2_W]}, 8'h07, "p2 oe");
        chk({5'h00, pad_o[P2_LSB+:P2_W]}, 8'h00, "p2 out");
        chk(8'(n_int - n0), 8'h01, "int from output");
        dual <= 1'b1;
        settle;
        chk({5'h00, pad_oe[P2_LSB+:P2_W]}, 8'h01, "dual clock");
        dual <= 1'b0;
        stop <= 1'b1;
        settle;
        chk({5'h00, pad_oe[P2_LSB+:P2_W]}, 8'h06, "stop p2");
        goe <= 1'b0;
        settle;
        chk(pad_oe[P1_LSB+:P1_W], 8'h00, "stop float");
        stop <= 1'b0;
        goe <= 1'b1;
        wr_reg(OFF_P2_LATCH, 8'h07);
        settle;
        rchk(OFF_P2_PIN, 8'h07, "p2 pins");
        n0 = n_int;
        ext_en[P2_LSB] <= 1'b1;
        settle;
        chk(8'(n_int - n0), 8'h01, "int from input");
        rchk(OFF_P2_PIN, 8'h06, "p2 low pin");
        $display("test second port done");
        final_report;
    end

    // Hang guard: the sequence needs well under 1000 cycles
    initial begin
        #200000;
        mismatches++;
        final_report;
    end
endmodule

`default_nettype wire
